// *** design/clpcr_pkg.sv ***
package clpcr_pkg;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [7:0] LOOP1_OFS = 8'h84;
  localparam logic [7:0] LOOP2_OFS = 8'h88;
  localparam logic [31:0] LOOP1_RST = 32'h00000000;
  localparam logic [31:0] LOOP2_RST = 32'h00000000;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int RATE_LSB = 13;
  localparam int CHOP_LSB = 11;
  localparam int PAIR_BIT = 10;
  localparam int SIGN_BIT = 9;
  localparam int MAG_LSB = 1;
  localparam int SURGE_BIT = 7;

  // ----------------------------------------------------------------
  // Rates and scales
  // ----------------------------------------------------------------
  localparam logic [14:0] CLK_KHZ = 15'h61A8;
  localparam logic [6:0] LOW_BASE_KHZ = 7'h05;
  localparam logic [6:0] HIGH_BASE_KHZ = 7'h19;
  localparam logic [6:0] HIGH_STEP_KHZ = 7'h05;
  localparam logic [4:0] HIGH_BAND_CODE = 5'h10;
  localparam logic [7:0] ADV_STEP_MDEG = 8'h78;

  // Modulation side codes.
  typedef enum logic [1:0] {
    CHOP_HIGH = 2'h0,
    CHOP_LOW = 2'h1,
    CHOP_MIXED = 2'h2,
    CHOP_UNDEF = 2'h3
  } clpcr_chop_e;

  // First closed-loop settings word.
  typedef struct packed {
    logic [13:0] upper_fields;
    logic [4:0] switch_rate_code;
    logic [1:0] chop_side_select;
    logic gate_complementary;
    logic advance_sign;
    logic [7:0] advance_magnitude;
    logic reserved;
  } clpcr_loop1_s;

  // Second closed-loop settings word.
  typedef struct packed {
    logic parity;
    logic [1:0] speed_pulse_mode;
    logic [3:0] speed_pulse_divider;
    logic speed_pulse_behaviour;
    logic [2:0] speed_pulse_emf_level;
    logic [2:0] halt_method;
    logic [3:0] halt_brake_duration;
    logic [2:0] spin_down_brake_level;
    logic [2:0] brake_duty_level;
    logic surge_guard_enable;
    logic [3:0] cycle_current_cap;
    logic [2:0] reserved;
  } clpcr_loop2_s;

  // Decoded drive settings for the commutation engine.
  typedef struct packed {
    logic high_chop;
    logic low_chop;
    logic complementary;
    logic signed [16:0] advance_mdeg;
  } clpcr_drive_s;

endpackage : clpcr_pkg

// *** design/clpcr_rate_gen.sv ***
`timescale 1ns/1ps
`default_nettype none

// Turns the switching-rate code into a rate in kHz and a period tick.
module clpcr_rate_gen (
  // Clock and reset.
  input wire logic sys_clk,
  input wire logic rst,
  // Rate selection.
  input wire logic [4:0] rate_code,
  // Results.
  output logic [6:0] rate_khz_ff,
  output logic tick_ff
);

  // ----------------------------------------------------------------
  // Rate decode
  // ----------------------------------------------------------------
  // Low band steps by 1 kHz, high band by 5 kHz.
  logic high_band;
  logic [6:0] nxt_rate_khz;
  logic [14:0] period_cyc;
  logic [14:0] cnt_ff;
  assign high_band = rate_code >= clpcr_pkg::HIGH_BAND_CODE;
  assign nxt_rate_khz = high_band ?
    7'(clpcr_pkg::HIGH_BASE_KHZ + clpcr_pkg::HIGH_STEP_KHZ * 7'(rate_code - clpcr_pkg::HIGH_BAND_CODE)) :
    7'(clpcr_pkg::LOW_BASE_KHZ + 7'(rate_code));
  // The divide runs on the registered rate so a new code settles first.
  assign period_cyc = (rate_khz_ff == 7'h00) ? 15'h0001 : 15'(clpcr_pkg::CLK_KHZ / 15'(rate_khz_ff));

  // Registered rate.
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      rate_khz_ff <= clpcr_pkg::LOW_BASE_KHZ;
    end else begin
      rate_khz_ff <= nxt_rate_khz;
    end
  end

  // Period counter, one tick per switching period.
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      cnt_ff <= 15'h0000;
      tick_ff <= 1'b0;
    end else if (cnt_ff + 15'h0001 >= period_cyc) begin
      cnt_ff <= 15'h0000;
      tick_ff <= 1'b1;
    end else begin
      cnt_ff <= cnt_ff + 15'h0001;
      tick_ff <= 1'b0;
    end
  end

endmodule : clpcr_rate_gen

`default_nettype wire

// *** design/clpcr_regs.sv ***
`timescale 1ns/1ps
`default_nettype none

// How it works
// - Bits 17:13 pick switching rate: 5-20 kHz by 1, then 25-100 by 5.
// - Bits 12:11 choose high, low or mixed chopping; code 3 invalid.
// - Bit 10 selects single-ended (0) or complementary (1) gate drive.
// - Bit 9 gives advance sign: 0 negative, 1 positive.
// - Bits 8:1 give advance angle as value times 0.12 degrees.
// - Second settings word sits at 88h and resets to zero.
// - Second word field layout from bit 31 down, all read-write.
module clpcr_regs (
  // Clock and reset.
  input wire logic sys_clk,
  input wire logic rst,
  // Register port.
  input wire logic [7:0] reg_addr,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [31:0] reg_wdata,
  output logic [31:0] reg_rdata_ff,
  output logic reg_rvalid_ff,
  // Settings to the commutation engine.
  output clpcr_pkg::clpcr_loop1_s loop1_ff,
  output clpcr_pkg::clpcr_loop2_s loop2_ff,
  output clpcr_pkg::clpcr_drive_s drive_ff,
  output logic [6:0] switch_rate_khz,
  output logic switch_tick
);

  // ----------------------------------------------------------------
  // Address decode
  // ----------------------------------------------------------------
  logic hit1;
  logic hit2;
  logic [31:0] rd_mux;
  assign hit1 = reg_addr == clpcr_pkg::LOOP1_OFS;
  assign hit2 = reg_addr == clpcr_pkg::LOOP2_OFS;
  assign rd_mux = hit1 ? loop1_ff : (hit2 ? loop2_ff : 32'h00000000);

  // Settings words; every field is plain read-write storage.
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      loop1_ff <= clpcr_pkg::LOOP1_RST;
      loop2_ff <= clpcr_pkg::LOOP2_RST;
    end else if (reg_wr) begin
      if (hit1) begin
        loop1_ff <= reg_wdata;
      end
      if (hit2) begin
        loop2_ff <= reg_wdata;
      end
    end
  end

  // Read answer one cycle after the strobe; unmapped reads give zero.
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      reg_rdata_ff <= 32'h00000000;
      reg_rvalid_ff <= 1'b0;
    end else begin
      reg_rdata_ff <= reg_rd ? rd_mux : reg_rdata_ff;
      reg_rvalid_ff <= reg_rd;
    end
  end

  // ----------------------------------------------------------------
  // Drive decode
  // ----------------------------------------------------------------
  // The undefined side code keeps the last valid choice.
  clpcr_pkg::clpcr_chop_e side;
  logic side_ok;
  logic nxt_high;
  logic nxt_low;
  logic signed [16:0] adv_abs;
  assign side = clpcr_pkg::clpcr_chop_e'(loop1_ff.chop_side_select);
  assign side_ok = side != clpcr_pkg::CHOP_UNDEF;
  assign nxt_high = side_ok ? (side != clpcr_pkg::CHOP_LOW) : drive_ff.high_chop;
  assign nxt_low = side_ok ? (side != clpcr_pkg::CHOP_HIGH) : drive_ff.low_chop;
  assign adv_abs = 17'(17'(loop1_ff.advance_magnitude) * 17'(clpcr_pkg::ADV_STEP_MDEG));

  // Registered drive settings.
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      drive_ff <= '0;
      drive_ff.high_chop <= 1'b1;
    end else begin
      drive_ff.high_chop <= nxt_high;
      drive_ff.low_chop <= nxt_low;
      drive_ff.complementary <= loop1_ff.gate_complementary;
      drive_ff.advance_mdeg <= loop1_ff.advance_sign ? adv_abs : -adv_abs;
    end
  end

  // Switching rate and period tick.
  clpcr_rate_gen u_rate (
    .sys_clk(sys_clk),
    .rst(rst),
    .rate_code(loop1_ff.switch_rate_code),
    .rate_khz_ff(switch_rate_khz),
    .tick_ff(switch_tick)
  );

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  sequence s_wr2;
    reg_wr && hit2;
  endsequence
  sequence s_rd2;
    reg_rd && hit2 && !reg_wr;
  endsequence

  property p_rate_low;
    @(posedge sys_clk) disable iff (rst)
    loop1_ff.switch_rate_code < 5'h10 |=> switch_rate_khz == 7'(5 + $past(loop1_ff.switch_rate_code));
  endproperty
  a_rate_low: assert property (p_rate_low) else $error("low band rate wrong");

  property p_rate_high;
    @(posedge sys_clk) disable iff (rst)
    loop1_ff.switch_rate_code >= 5'h10 |=>
      switch_rate_khz == 7'(25 + 5 * ($past(loop1_ff.switch_rate_code) - 16));
  endproperty
  a_rate_high: assert property (p_rate_high) else $error("high band rate wrong");

  property p_chop_valid;
    @(posedge sys_clk) disable iff (rst)
    loop1_ff.chop_side_select != 2'h3 |=>
      drive_ff.high_chop == ($past(loop1_ff.chop_side_select) != 2'h1) &&
      drive_ff.low_chop == ($past(loop1_ff.chop_side_select) != 2'h0);
  endproperty
  a_chop_valid: assert property (p_chop_valid) else $error("chop side decode wrong");

  property p_chop_undef;
    @(posedge sys_clk) disable iff (rst)
    loop1_ff.chop_side_select == 2'h3 |=> $stable(drive_ff.high_chop) && $stable(drive_ff.low_chop);
  endproperty
  a_chop_undef: assert property (p_chop_undef) else $error("undefined chop code changed drive");

  property p_pairing;
    @(posedge sys_clk) disable iff (rst)
    reg_wr && hit1 |-> ##2 drive_ff.complementary == $past(reg_wdata[clpcr_pkg::PAIR_BIT], 2);
  endproperty
  a_pairing: assert property (p_pairing) else $error("gate pairing not applied");

  property p_advance;
    @(posedge sys_clk) disable iff (rst)
    1'b1 |=> drive_ff.advance_mdeg == ($past(loop1_ff.advance_sign) ?
      17'sd120 * $signed({9'h000, $past(loop1_ff.advance_magnitude)}) :
      -17'sd120 * $signed({9'h000, $past(loop1_ff.advance_magnitude)}));
  endproperty
  a_advance: assert property (p_advance) else $error("advance angle wrong");

  property p_loop2_rw;
    @(posedge sys_clk) disable iff (rst)
    s_wr2 ##1 s_rd2 |=> reg_rvalid_ff && reg_rdata_ff == $past(reg_wdata, 2);
  endproperty
  a_loop2_rw: assert property (p_loop2_rw) else $error("second word readback wrong");

  property p_loop2_reset;
    @(posedge sys_clk) rst |=> loop2_ff == 32'h00000000;
  endproperty
  a_loop2_reset: assert property (p_loop2_reset) else $error("second word reset wrong");

  property p_surge_bit;
    @(posedge sys_clk) disable iff (rst)
    s_wr2 |=> loop2_ff.surge_guard_enable == $past(reg_wdata[clpcr_pkg::SURGE_BIT]);
  endproperty
  a_surge_bit: assert property (p_surge_bit) else $error("surge enable not at bit 7");

  // Register port handshake and decode.
  sequence s_rd_none;
    reg_rd && !hit1 && !hit2;
  endsequence
  sequence s_wr_none;
    reg_wr && !hit1 && !hit2;
  endsequence

  property p_rvalid_pulse;
    @(posedge sys_clk) disable iff (rst)
    1'b1 |=> reg_rvalid_ff == $past(reg_rd);
  endproperty
  a_rvalid_pulse: assert property (p_rvalid_pulse) else $error("read valid pulse wrong");

  property p_unmapped_zero;
    @(posedge sys_clk) disable iff (rst)
    s_rd_none |=> reg_rdata_ff == 32'h00000000;
  endproperty
  a_unmapped_zero: assert property (p_unmapped_zero) else $error("unmapped read not zero");

  property p_write_ignored;
    @(posedge sys_clk) disable iff (rst)
    s_wr_none |=> $stable(loop1_ff) && $stable(loop2_ff);
  endproperty
  a_write_ignored: assert property (p_write_ignored) else $error("unmapped write changed a word");

  property p_loop1_write;
    @(posedge sys_clk) disable iff (rst)
    reg_wr && hit1 |=> loop1_ff == $past(reg_wdata);
  endproperty
  a_loop1_write: assert property (p_loop1_write) else $error("first word write lost");

  // Decoded outputs after reset and in steady running.
  property p_drive_reset;
    @(posedge sys_clk)
    rst |=> drive_ff.high_chop && !drive_ff.low_chop && !drive_ff.complementary &&
      drive_ff.advance_mdeg == 17'sh00000;
  endproperty
  a_drive_reset: assert property (p_drive_reset) else $error("drive reset state wrong");

  property p_rate_reset;
    @(posedge sys_clk)
    rst |=> switch_rate_khz == 7'h05 && !switch_tick;
  endproperty
  a_rate_reset: assert property (p_rate_reset) else $error("rate reset state wrong");

  property p_tick_pulse;
    @(posedge sys_clk) disable iff (rst)
    switch_tick |=> !switch_tick;
  endproperty
  a_tick_pulse: assert property (p_tick_pulse) else $error("period tick longer than one cycle");

  property p_comp_follow;
    @(posedge sys_clk) disable iff (rst)
    1'b1 |=> drive_ff.complementary == $past(loop1_ff.gate_complementary);
  endproperty
  a_comp_follow: assert property (p_comp_follow) else $error("gate pairing does not follow word");

endmodule : clpcr_regs

`default_nettype wire

// *** tb/tb.sv ***
`timescale 1ns/1ps
`default_nettype none

module tb;
  logic sys_clk;
  logic rst;
  logic [7:0] reg_addr;
  logic reg_wr;
  logic reg_rd;
  logic [31:0] reg_wdata;
  logic [31:0] reg_rdata_ff;
  logic reg_rvalid_ff;
  clpcr_pkg::clpcr_loop1_s loop1_ff;
  clpcr_pkg::clpcr_loop2_s loop2_ff;
  clpcr_pkg::clpcr_drive_s drive_ff;
  logic [6:0] switch_rate_khz;
  logic switch_tick;
  int fails;
  int checks_done;

  clpcr_regs clpcr_regs_inst (.sys_clk(sys_clk), .rst(rst), .reg_addr(reg_addr), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata_ff(reg_rdata_ff), .reg_rvalid_ff(reg_rvalid_ff),
    .loop1_ff(loop1_ff), .loop2_ff(loop2_ff), .drive_ff(drive_ff), .switch_rate_khz(switch_rate_khz),
    .switch_tick(switch_tick));

  // Clock of 40 ns period.
  always #20 sys_clk = ~sys_clk;

  // -------------------------------------------------------------
  // Shared tasks
  // -------------------------------------------------------------
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      fails++;
      $display("unexpected %s: expected %h, seen %h", what, exp, seen);
    end
  endtask : chk

  task automatic end_sim();
    $display("checks %0d, mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : end_sim

  // Writes one word, then lets the decoded outputs settle.
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
    @(posedge sys_clk);
    #1;
  endtask : wr

  // Reads one word; the answer stands for one cycle after the taking edge.
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1;
    chk("read valid", {31'h0, reg_rvalid_ff}, 32'h1);
    d = reg_rdata_ff;
  endtask : rd

  // Builds a first settings word from its lower fields.
  function automatic logic [31:0] w1(input logic [4:0] r, input logic [1:0] c, input logic p, input logic s,
    input logic [7:0] m);
    return {14'h0, r, c, p, s, m, 1'b0};
  endfunction : w1

  // Waits for the next tick and returns the cycles spent.
  task automatic next_tick(output int n);
    n = 0;
    do begin
      @(posedge sys_clk);
      #1;
      n++;
      if (n > 6000) begin
        fails++;
        end_sim();
      end
    end while (switch_tick !== 1'b1);
  endtask : next_tick

  // -------------------------------------------------------------
  // Scenarios
  // -------------------------------------------------------------
  task automatic t_reset();
    logic [31:0] d;
    chk("loop1 reset", loop1_ff, 32'h0);
    chk("loop2 reset", loop2_ff, clpcr_pkg::LOOP2_RST);
    chk("drive reset", {12'h0, drive_ff}, 32'h00080000);
    chk("rate reset", {25'h0, switch_rate_khz}, 32'h5);
    rd(clpcr_pkg::LOOP2_OFS, d);
    chk("second word reset read", d, 32'h0);
    $display("test reset done");
  endtask : t_reset

  task automatic t_loop2();
    logic [31:0] d;
    wr(8'h88, 32'hDEADBEEF);
    rd(8'h88, d);
    chk("second word read", d, 32'hDEADBEEF);
    chk("surge enable", {31'h0, loop2_ff.surge_guard_enable}, 32'h1);
    chk("halt method", {29'h0, loop2_ff.halt_method}, 32'h3);
    chk("pulse mode", {30'h0, loop2_ff.speed_pulse_mode}, 32'h2);
    chk("current cap", {28'h0, loop2_ff.cycle_current_cap}, 32'hD);
    $display("test second word done");
  endtask : t_loop2

  task automatic t_rate();
    for (int c = 0; c < 32; c++) begin
      wr(8'h84, w1(5'(c), 2'h0, 1'b0, 1'b0, 8'h00));
      chk("rate khz", {25'h0, switch_rate_khz}, 32'((c < 16) ? 5 + c : 25 + 5 * (c - 16)));
    end
    $display("test rate codes done");
  endtask : t_rate

  task automatic t_chop();
    logic [1:0] exp [4] = '{2'b10, 2'b01, 2'b11, 2'b11};
    for (int c = 0; c < 4; c++) begin
      wr(8'h84, w1(5'h00, 2'(c), 1'b0, 1'b0, 8'h00));
      chk("chop sides", {30'h0, drive_ff.high_chop, drive_ff.low_chop}, {30'h0, exp[c]});
    end
    $display("test chop side done");
  endtask : t_chop

  task automatic t_adv();
    logic [31:0] d;
    wr(8'h84, w1(5'h00, 2'h0, 1'b1, 1'b1, 8'hFF));
    chk("complementary", {31'h0, drive_ff.complementary}, 32'h1);
    chk("advance", 32'(drive_ff.advance_mdeg), 32'(30600));
    rd(8'h84, d);
    chk("first word read", d, 32'h000007FE);
    wr(8'h84, w1(5'h00, 2'h0, 1'b0, 1'b0, 8'h01));
    chk("single ended", {31'h0, drive_ff.complementary}, 32'h0);
    chk("advance negative", 32'(drive_ff.advance_mdeg), 32'(-120));
    $display("test advance done");
  endtask : t_adv

  task automatic t_tick();
    int n;
    logic [4:0] codes [3] = '{5'h1F, 5'h0A, 5'h00};
    int per [3] = '{250, 1666, 5000};
    for (int i = 0; i < 3; i++) begin
      wr(8'h84, w1(codes[i], 2'h0, 1'b0, 1'b0, 8'h00));
      next_tick(n);
      next_tick(n);
      chk("tick period", 32'(n), 32'(per[i]));
    end
    $display("test tick period done");
  endtask : t_tick

  task automatic t_unmapped();
    logic [31:0] d;
    wr(8'h80, 32'hFFFFFFFF);
    rd(8'h80, d);
    chk("unmapped read", d, 32'h0);
    chk("first word kept", loop1_ff, 32'h0);
    chk("second word kept", loop2_ff, 32'hDEADBEEF);
    $display("test unmapped done");
  endtask : t_unmapped

  // Write then read back to back, then a read and a write in one cycle.
  task automatic t_b2b();
    @(posedge sys_clk);
    reg_addr <= clpcr_pkg::LOOP2_OFS;
    reg_wdata <= 32'h12345678;
    reg_wr <= 1'b1;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
    reg_rd <= 1'b1;
    @(posedge sys_clk);
    reg_wr <= 1'b1;
    reg_wdata <= 32'hDEADBEEF;
    #1;
    chk("back to back read", reg_rdata_ff, 32'h12345678);
    @(posedge sys_clk);
    reg_wr <= 1'b0;
    reg_rd <= 1'b0;
    #1;
    chk("read beside write", reg_rdata_ff, 32'h12345678);
    chk("read beside write valid", {31'h0, reg_rvalid_ff}, 32'h1);
    chk("write beside read", loop2_ff, 32'hDEADBEEF);
    $display("test back to back done");
  endtask : t_b2b

  // Main sequence: reset for 10 cycles, then every scenario.
  initial begin
    sys_clk = 1'b0;
    rst = 1'b1;
    reg_addr = 8'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_wdata = 32'h0;
    fails = 0;
    checks_done = 0;
    repeat (10) @(posedge sys_clk);
    rst <= 1'b0;
    #1;
    t_reset();
    t_loop2();
    t_rate();
    t_chop();
    t_adv();
    t_tick();
    t_unmapped();
    t_b2b();
    end_sim();
  end
endmodule : tb

`default_nettype wire
